// ---- fqrb_top.sv ----
/*
 * frame queue control and receive breakpoint batching: AHB-Lite register
 * slave paced by a ring tick, limit table, pointer reads and confirmation
 * writes on a shared memory bus, token grants, breakpoint rules, interrupt.
 * assumes ring-side inputs synchronous to CLK_SYS and one frame engine
 * that owns the memory bus while granted.
 */
`timescale 1ns/1ps
`include "fqrb_map.svh"

module fqrb_top
	import fqrb_pkg::*;
#(
	parameter int NQ = 8,
	parameter int NCH = 4,
	parameter logic [31:0] PTR_BASE = 32'h0000_0000,
	parameter logic [31:0] CNF_BASE = 32'h0000_1000
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RSTN, // async reset, low
	input wire logic HSEL, // slave select
	input wire logic [31:0] HADDR, // byte address
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HWRITE, // write when high
	input wire logic [2:0] HSIZE, // word only
	input wire logic HREADY, // bus ready in
	input wire logic [31:0] HWDATA, // write data
	output logic [31:0] HRDATA, // read data
	output logic HREADYOUT, // slave ready
	output logic HRESP, // always okay
	input wire logic RX_FRAME_END, // frame received pulse
	input wire logic [1:0] RX_CHAN, // receive channel
	input wire logic [47:0] RX_DA, // destination address
	input wire logic [47:0] RX_SA, // source address
	input wire logic [31:0] RX_INFO4, // first info octets
	input wire logic TOKEN_SEEN, // other station's opportunity end
	input wire logic TOKEN_CAPTURED, // our token opportunity
	input wire logic TX_OBJ_PENDING, // request object queued
	output logic TX_GRANT, // object may transmit
	input wire logic TX_OBJ_DONE, // request object completed
	input wire logic [7:0] TX_OBJ_UID, // its identifier
	input wire logic FRAME_MEM_REQ, // frame engine wants bus
	output logic FRAME_MEM_GNT, // frame engine owns bus
	output logic MEM_VALID, // own memory access
	output logic MEM_WRITE, // write when high
	output logic [31:0] MEM_ADDR, // byte address
	output logic [31:0] MEM_WDATA, // write data
	input wire logic MEM_READY, // access done
	input wire logic [31:0] MEM_RDATA, // read data
	output logic IRQ // level interrupt
);

	localparam int QW = $clog2(NQ);

	// one-hot of a receive channel
	function automatic logic [NCH-1:0] chan_bit(input logic [1:0] ch);
		chan_bit = '0;
		chan_bit[ch] = 1'b1;
	endfunction

	// ---------------------------------------------------------------
	// ring tick: free-running divider standing in for the ring clock
	// ---------------------------------------------------------------
	logic [1:0] div_q;
	logic ring_tick;
	assign ring_tick = (div_q == 2'(`FQRB_RING_DIV - 1));

	// the ring timing lives in this tick, so no second clock needs crossing
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			div_q <= 2'h0;
		end else begin
			div_q <= ring_tick ? 2'h0 : div_q + 2'h1;
		end
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave: address captured, data phase stretched by ticks
	// ---------------------------------------------------------------
	fqrb_bus_e bus_q;
	logic [7:0] adr_q;
	logic wr_q;
	logic [2:0] tick_q;
	logic done;
	logic [31:0] rdata;
	assign done = (bus_q == BUS_WAIT) && ring_tick && (tick_q == 3'(`FQRB_ACC_TICKS - 1));
	assign HREADYOUT = (bus_q == BUS_IDLE);
	assign HRESP = 1'b0;

	// every access waits five ring ticks, i.e. 17 to 20 system cycles
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			bus_q <= BUS_IDLE;
			adr_q <= 8'h00;
			wr_q <= 1'b0;
			tick_q <= 3'h0;
		end else if (bus_q == BUS_IDLE) begin
			if (HSEL && HTRANS[1] && HREADY) begin
				bus_q <= BUS_WAIT;
				adr_q <= HADDR[7:0];
				wr_q <= HWRITE;
				tick_q <= 3'h0;
			end
		end else if (done) begin
			bus_q <= BUS_IDLE;
		end else if (ring_tick) begin
			tick_q <= tick_q + 3'h1;
		end
	end

	logic wr_now;
	assign wr_now = done && wr_q;

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	logic [3:0] ctrl_q;
	logic [7:0] thr_q;
	logic [5:0] notify_q;
	logic [QW-1:0] lim_sel_q;
	logic [15:0] lim_q [NQ];
	logic [QW-1:0] ptr_idx_q;
	logic ptr_pend_q;
	logic [31:0] ptr_val_q;
	logic [5:0] status_q;

	// config written only by the host
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q <= `FQRB_CTRL_RST;
			thr_q <= `FQRB_THR_RST;
			notify_q <= 6'h00;
			lim_sel_q <= '0;
		end else if (wr_now) begin
			if (adr_q == `FQRB_OFF_CTRL) ctrl_q <= HWDATA[3:0];
			if (adr_q == `FQRB_OFF_THRESH) thr_q <= HWDATA[7:0];
			if (adr_q == `FQRB_OFF_NOTIFY) notify_q <= HWDATA[5:0];
			if (adr_q == `FQRB_OFF_LIM_SEL) lim_sel_q <= HWDATA[QW-1:0];
		end
	end

	// limit table: no internal path ever writes it
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NQ; i++) lim_q[i] <= 16'h0000;
		end else if (wr_now && adr_q == `FQRB_OFF_LIM_VAL) begin
			lim_q[lim_sel_q] <= HWDATA[15:0];
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (adr_q)
			`FQRB_OFF_CTRL: rdata[3:0] = ctrl_q;
			`FQRB_OFF_THRESH: rdata[7:0] = thr_q;
			`FQRB_OFF_STATUS: rdata[5:0] = status_q;
			`FQRB_OFF_NOTIFY: rdata[5:0] = notify_q;
			`FQRB_OFF_LIM_SEL: rdata[QW-1:0] = lim_sel_q;
			`FQRB_OFF_LIM_VAL: rdata[15:0] = lim_q[lim_sel_q];
			`FQRB_OFF_PTR_REQ: rdata[QW-1:0] = ptr_idx_q;
			`FQRB_OFF_PTR_VAL: begin
				rdata = ptr_val_q;
				rdata[`FQRB_PTR_BUSY] = ptr_pend_q;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	// read data held from the completing edge
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) HRDATA <= 32'h0000_0000;
		else if (done && !wr_q) HRDATA <= rdata;
	end

	// ---------------------------------------------------------------
	// memory bus: frame data first, confirmations, pointer reads last
	// ---------------------------------------------------------------
	fqrb_mem_e mem_q;
	fqrb_own_e own_q;
	logic cnf_pend_q;
	logic [7:0] cnf_uid_q;
	logic [QW-1:0] cnf_ptr_q;
	logic cnf_take, ptr_take, cnf_fin, ptr_fin, ptr_req;
	assign ptr_req = wr_now && adr_q == `FQRB_OFF_PTR_REQ;
	assign cnf_take = (mem_q == MEM_IDLE) && !FRAME_MEM_REQ && cnf_pend_q;
	assign ptr_take = (mem_q == MEM_IDLE) && !FRAME_MEM_REQ && !cnf_pend_q && ptr_pend_q;
	assign cnf_fin = (mem_q == MEM_BUSY) && MEM_READY && own_q == OWN_CNF;
	assign ptr_fin = (mem_q == MEM_BUSY) && MEM_READY && own_q == OWN_PTR;

	// single outstanding access; the frame engine is granted while we idle
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mem_q <= MEM_IDLE;
			own_q <= OWN_CNF;
			FRAME_MEM_GNT <= 1'b0;
			MEM_VALID <= 1'b0;
			MEM_WRITE <= 1'b0;
			MEM_ADDR <= 32'h0000_0000;
			MEM_WDATA <= 32'h0000_0000;
		end else if (mem_q == MEM_IDLE) begin
			FRAME_MEM_GNT <= FRAME_MEM_REQ;
			if (cnf_take) begin
				mem_q <= MEM_BUSY;
				own_q <= OWN_CNF;
				MEM_VALID <= 1'b1;
				MEM_WRITE <= 1'b1;
				MEM_ADDR <= CNF_BASE + {cnf_ptr_q, 2'b00};
				MEM_WDATA <= {24'h000000, cnf_uid_q};
			end else if (ptr_take) begin
				mem_q <= MEM_BUSY;
				own_q <= OWN_PTR;
				MEM_VALID <= 1'b1;
				MEM_WRITE <= 1'b0;
				MEM_ADDR <= PTR_BASE + {ptr_idx_q, 2'b00};
			end
		end else if (MEM_READY) begin
			mem_q <= MEM_IDLE;
			MEM_VALID <= 1'b0;
		end
	end

	// pointer read request and result; a new request while busy is dropped
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ptr_idx_q <= '0;
			ptr_pend_q <= 1'b0;
			ptr_val_q <= 32'h0000_0000;
		end else begin
			if (ptr_req && !ptr_pend_q) begin
				ptr_idx_q <= HWDATA[QW-1:0];
				ptr_pend_q <= 1'b1;
			end else if (ptr_fin) begin
				ptr_pend_q <= 1'b0;
			end
			if (ptr_fin) ptr_val_q <= MEM_RDATA;
		end
	end

	// ---------------------------------------------------------------
	// transmit: grant per token, confirmation on completion
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) TX_GRANT <= 1'b0;
		else TX_GRANT <= TOKEN_CAPTURED && TX_OBJ_PENDING;
	end

	// only one confirmation waits; a new completion overwrites its uid
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			cnf_pend_q <= 1'b0;
			cnf_uid_q <= 8'h00;
			cnf_ptr_q <= '0;
		end else begin
			if (TX_OBJ_DONE && ctrl_q[`FQRB_CTRL_TEND]) begin
				cnf_pend_q <= 1'b1;
				cnf_uid_q <= TX_OBJ_UID;
			end else if (cnf_take) begin
				cnf_pend_q <= 1'b0;
			end
			if (cnf_fin) cnf_ptr_q <= cnf_ptr_q + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// receive breakpoint rules
	// ---------------------------------------------------------------
	logic [129:0] prev_q;
	logic prev_ok_q;
	logic [1:0] prev_ch_q;
	logic [7:0] cnt_q;
	logic [NCH-1:0] seen_q;
	logic [129:0] cur;
	logic burst;
	logic [7:0] cnt_inc;
	logic [NCH-1:0] seen_all, bp_set;
	assign cur = {RX_DA, RX_SA, RX_INFO4, RX_CHAN};
	assign burst = RX_FRAME_END && prev_ok_q && (cur != prev_q);
	assign cnt_inc = burst ? 8'h01 : cnt_q + 8'h01;
	assign seen_all = seen_q | (RX_FRAME_END ? chan_bit(RX_CHAN) : '0);

	// channel 0 breaks only on opportunity end
	always_comb begin
		bp_set = '0;
		if (ctrl_q[`FQRB_CTRL_BOB] && burst && prev_ch_q != 2'h0) begin
			bp_set = bp_set | chan_bit(prev_ch_q);
		end
		if (ctrl_q[`FQRB_CTRL_BOT] && RX_FRAME_END && RX_CHAN != 2'h0 &&
			thr_q != 8'h00 && cnt_inc >= thr_q) begin
			bp_set = bp_set | chan_bit(RX_CHAN);
		end
		if (ctrl_q[`FQRB_CTRL_BOS] && TOKEN_SEEN) begin
			bp_set = bp_set | seen_all;
		end
	end

	// previous frame, counter and seen channels
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			prev_q <= '0;
			prev_ok_q <= 1'b0;
			prev_ch_q <= 2'h0;
			cnt_q <= 8'h00;
			seen_q <= '0;
		end else begin
			if (RX_FRAME_END) begin
				prev_q <= cur;
				prev_ok_q <= 1'b1;
				prev_ch_q <= RX_CHAN;
			end
			if (TOKEN_SEEN) begin
				cnt_q <= 8'h00;
				seen_q <= '0;
			end else begin
				seen_q <= seen_all;
				if (RX_FRAME_END) begin
					cnt_q <= (thr_q != 8'h00 && cnt_inc >= thr_q) ? 8'h00 : cnt_inc;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// attention and interrupt; a set in the clear cycle wins
	// ---------------------------------------------------------------
	logic [5:0] ev_set, ev_clr;
	assign ev_set = {ptr_fin, cnf_fin, bp_set};
	assign ev_clr = (wr_now && adr_q == `FQRB_OFF_CLEAR) ? HWDATA[5:0] : 6'h00;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) status_q <= 6'h00;
		else status_q <= (status_q & ~ev_clr) | ev_set;
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) IRQ <= 1'b0;
		else IRQ <= |(status_q & notify_q);
	end

endmodule

// ---- fqrb_map.svh ----
/*
 * register offsets, field positions, reset values and timing counts of the
 * frame queue and receive breakpoint block.
 * assumes a 50 MHz system clock and AHB-Lite word accesses only.
 */
// Contract
// - bus access completes in 4-5 ring periods
// - system and ring timing kept apart, crossed inside; here one clock, ring as a CLK_SYS tick
// - device never changes limit values itself
// - pointer read on memory bus, lowest priority
// - one request object granted per token
// - transmit-end class writes confirmation descriptor
// - token ends opportunity, breakpoint if frames seen
// - burst change in addresses/info/channel breaks
// - frame count threshold breaks, one means every
// - frame counter cleared per opportunity and burst
// - host enables each interrupt source individually
// - status masked by notify, ORed to interrupt
`ifndef FQRB_MAP_SVH
`define FQRB_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FQRB_OFF_CTRL 8'h00
`define FQRB_OFF_THRESH 8'h04
`define FQRB_OFF_STATUS 8'h08
`define FQRB_OFF_CLEAR 8'h0c
`define FQRB_OFF_NOTIFY 8'h10
`define FQRB_OFF_LIM_SEL 8'h14
`define FQRB_OFF_LIM_VAL 8'h18
`define FQRB_OFF_PTR_REQ 8'h1c
`define FQRB_OFF_PTR_VAL 8'h20

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define FQRB_CTRL_BOS 0
`define FQRB_CTRL_BOB 1
`define FQRB_CTRL_BOT 2
`define FQRB_CTRL_TEND 3
`define FQRB_ST_CNF 4
`define FQRB_ST_PTR 5
`define FQRB_PTR_BUSY 31
`define FQRB_CTRL_RST 4'h0
`define FQRB_THR_RST 8'h01

// ---------------------------------------------------------------
// timing: ring tick derived from the system clock
// ---------------------------------------------------------------
`define FQRB_SYS_PERIOD_NS 20
`define FQRB_RING_PERIOD_NS 80
`define FQRB_RING_DIV (`FQRB_RING_PERIOD_NS / `FQRB_SYS_PERIOD_NS)
`define FQRB_ACC_TICKS 5

`endif

// ---- fqrb_pkg.sv ----
/*
 * types shared by the frame queue and receive breakpoint block.
 * assumes nothing of its surroundings.
 */
package fqrb_pkg;
	typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_WAIT = 1'b1} fqrb_bus_e;
	typedef enum logic [0:0] {MEM_IDLE = 1'b0, MEM_BUSY = 1'b1} fqrb_mem_e;
	typedef enum logic [0:0] {OWN_CNF = 1'b0, OWN_PTR = 1'b1} fqrb_own_e;
endpackage

// ---- fqrb_top_properties.sv ----
/*
 * port-level checks of the frame queue and receive breakpoint block.
 * assumes it is bound onto fqrb_top and sees only that module's ports.
 */
`timescale 1ns/1ps

module fqrb_top_checker (
	input wire logic CLK_SYS, // system clock
	input wire logic RSTN, // reset, low
	input wire logic HSEL, // slave select
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HREADY, // bus ready in
	input wire logic HREADYOUT, // slave ready
	input wire logic TOKEN_CAPTURED, // our opportunity
	input wire logic TX_OBJ_PENDING, // object queued
	input wire logic TX_GRANT, // object may transmit
	input wire logic FRAME_MEM_REQ, // frame engine wants bus
	input wire logic FRAME_MEM_GNT, // frame engine owns bus
	input wire logic MEM_VALID, // own access
	input wire logic MEM_WRITE, // write when high
	input wire logic [31:0] MEM_ADDR, // byte address
	input wire logic [31:0] MEM_WDATA, // write data
	input wire logic MEM_READY, // access done
	input wire logic IRQ // level interrupt
);
	// ----------------------------------------------------------
	// helpers and properties
	// ----------------------------------------------------------
	logic take;
	logic grant_due;
	// named causes, since the sampled-value functions want plain signals
	assign take = HSEL && HTRANS[1] && HREADY && HREADYOUT;
	assign grant_due = TOKEN_CAPTURED && TX_OBJ_PENDING;
	default clocking dc @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	access_time_a: assert property (
		take |=> (!HREADYOUT) [*8] ##1 (!HREADYOUT) [*8] ##[2:5] HREADYOUT)
		else $error("bus access not finished in 18 to 21 cycles");
	access_start_a: assert property ($fell(HREADYOUT) |-> $past(take))
		else $error("wait state without a taken transfer");
	grant_due_a: assert property (grant_due |=> TX_GRANT)
		else $error("token with pending object gave no grant");
	grant_cause_a: assert property (TX_GRANT |-> $past(grant_due))
		else $error("grant without token and pending object");
	mem_yield_a: assert property ($rose(MEM_VALID) |-> !$past(FRAME_MEM_REQ))
		else $error("own access started over frame traffic");
	mem_hold_a: assert property (MEM_VALID && !MEM_READY |=> MEM_VALID &&
		$stable(MEM_ADDR) && $stable(MEM_WDATA) && $stable(MEM_WRITE))
		else $error("own access changed before ready");
	mem_release_a: assert property (MEM_VALID && MEM_READY |=> !MEM_VALID)
		else $error("own access not released after ready");
	frame_grant_a: assert property (!MEM_VALID && FRAME_MEM_REQ |=> FRAME_MEM_GNT)
		else $error("frame engine not granted an idle bus");
	bus_exclusive_a: assert property (FRAME_MEM_GNT |-> !MEM_VALID)
		else $error("two owners on the memory bus");
	cover property (TX_GRANT);
	cover property (MEM_VALID && MEM_WRITE && MEM_READY);
	cover property ($rose(IRQ));
endmodule

bind fqrb_top fqrb_top_checker fqrb_top_checker_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.HSEL(HSEL), .HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.TOKEN_CAPTURED(TOKEN_CAPTURED), .TX_OBJ_PENDING(TX_OBJ_PENDING), .TX_GRANT(TX_GRANT),
	.FRAME_MEM_REQ(FRAME_MEM_REQ), .FRAME_MEM_GNT(FRAME_MEM_GNT), .MEM_VALID(MEM_VALID),
	.MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
	.MEM_READY(MEM_READY), .IRQ(IRQ));

// ---- fqrb_mem_model.sv ----
/*
 * shared descriptor memory on the host side of the block's memory bus.
 * assumes one access outstanding, held until ready is seen.
 */
`timescale 1ns/1ps

module fqrb_mem_model (
	input wire logic clk, // system clock
	input wire logic rst_n, // reset, low
	input wire logic slow, // three wait cycles when high
	input wire logic mem_valid, // access request
	input wire logic mem_write, // write when high
	input wire logic [31:0] mem_addr, // byte address
	input wire logic [31:0] mem_wdata, // write data
	output logic mem_ready, // access done
	output logic [31:0] mem_rdata, // read data
	output logic [31:0] last_addr, // last written address
	output logic [31:0] last_wdata // last written word
);
	// ----------------------------------------------------------
	// answer and capture
	// ----------------------------------------------------------
	logic [1:0] wait_q;
	// read data toggles outside ready so early sampling cannot pass
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ready <= 1'b0;
			wait_q <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_ready) begin
			mem_ready <= 1'b0;
			wait_q <= 2'h0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_valid && (!slow || wait_q == 2'h3)) begin
			mem_ready <= 1'b1;
			mem_rdata <= mem_addr ^ 32'h5a5a_0000;
		end else begin
			wait_q <= mem_valid ? wait_q + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
	// last word written, for confirmation checks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_addr <= 32'h0;
			last_wdata <= 32'h0;
		end else if (mem_valid && mem_write && mem_ready) begin
			last_addr <= mem_addr;
			last_wdata <= mem_wdata;
		end
	end
endmodule

// ---- fqrb_top_test.sv ----
/*
 * self-checking bench of fqrb_top: AHB-Lite master, ring-side stimulus.
 * assumes the checker and the memory model are compiled before it.
 */
`timescale 1ns/1ps
`include "fqrb_map.svh"

module fqrb_top_test;
	// ----------------------------------------------------------
	// stimulus, monitor and scenarios
	// ----------------------------------------------------------
	logic clk = 0, rstn = 0, wr = 0, rd_ph = 0, fe = 0, tok = 0, cap = 0, pend = 0;
	logic done = 0, freq = 0, slow = 0, rdy, rdy_s = 1, irq, fgnt, mv, mw, mr, gnt, hresp;
	logic [1:0] tr = 0, ch = 0;
	logic [7:0] uid = 0;
	logic [31:0] ad = 0, wd = 0, rdat, info = 0, ma, mwd, mrd, la, lw;
	logic [31:0] seed = 32'h1d18e6dc;
	logic [47:0] da = 0, sa = 0;
	logic [31:0] q[$];
	int miscompares = 0, comparisons = 0, cyc = 0;

	fqrb_top fqrb_top_inst (.CLK_SYS(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(ad),
		.HTRANS(tr), .HWRITE(wr), .HSIZE(3'h2), .HREADY(rdy), .HWDATA(wd),
		.HRDATA(rdat), .HREADYOUT(rdy), .HRESP(hresp), .RX_FRAME_END(fe), .RX_CHAN(ch),
		.RX_DA(da), .RX_SA(sa), .RX_INFO4(info), .TOKEN_SEEN(tok),
		.TOKEN_CAPTURED(cap), .TX_OBJ_PENDING(pend), .TX_GRANT(gnt), .TX_OBJ_DONE(done),
		.TX_OBJ_UID(uid), .FRAME_MEM_REQ(freq), .FRAME_MEM_GNT(fgnt), .MEM_VALID(mv),
		.MEM_WRITE(mw), .MEM_ADDR(ma), .MEM_WDATA(mwd), .MEM_READY(mr),
		.MEM_RDATA(mrd), .IRQ(irq));
	fqrb_mem_model fqrb_mem_model_inst (.clk(clk), .rst_n(rstn), .slow(slow),
		.mem_valid(mv), .mem_write(mw), .mem_addr(ma), .mem_wdata(mwd), .mem_ready(mr),
		.mem_rdata(mrd), .last_addr(la), .last_wdata(lw));

	// free-running 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one single transfer; ready is taken from the half cycle before the edge,
	// since the slave drops it at the very edge that takes the address
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		tr <= 2'h2;
		wr <= w;
		ad <= {24'h0, a};
		@(posedge clk);
		while (rdy_s !== 1'b1) @(posedge clk);
		tr <= 2'h0;
		wd <= d;
		rd_ph <= !w;
		@(posedge clk);
		while (rdy_s !== 1'b1) @(posedge clk);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic frame(input logic [1:0] c);
		fe <= 1'b1;
		ch <= c;
		@(posedge clk);
		fe <= 1'b0;
		@(posedge clk);
	endtask
	task automatic tokp;
		tok <= 1'b1;
		@(posedge clk);
		tok <= 1'b0;
		@(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({31'h0, irq}, {31'h0, e});
		@(posedge clk);
	endtask

	// read data and ready are settled by the falling edge
	always @(negedge clk) begin
		rdy_s = rdy;
		if (rd_ph && rdy) begin
			check(rdat, q.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
	end
	// hang guard: the whole run needs about 800 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(`FQRB_OFF_THRESH, 32'h1);
		rd(8'h24, 32'h0);
		bus(1'b1, `FQRB_OFF_LIM_SEL, 32'h5);
		bus(1'b1, `FQRB_OFF_LIM_VAL, 32'hbeef);
		bus(1'b1, `FQRB_OFF_CTRL, 32'h4);
		da <= {seed[15:0], seed};
		frame(2'h2);
		rd(`FQRB_OFF_STATUS, 32'h4);
		irq_is(1'b0);
		bus(1'b1, `FQRB_OFF_NOTIFY, 32'h4);
		irq_is(1'b1);
		bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		rd(`FQRB_OFF_STATUS, 32'h0);
		irq_is(1'b0);
		bus(1'b1, `FQRB_OFF_THRESH, 32'h3);
		// two frames, a token, then three frames more reach the threshold
		for (int i = 0; i < 5; i++) begin
			if (i == 2) tokp();
			frame(2'h1);
			if (i == 2) rd(`FQRB_OFF_STATUS, 32'h0);
		end
		rd(`FQRB_OFF_STATUS, 32'h2);
		bus(1'b1, `FQRB_OFF_CTRL, 32'h2);
		bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		frame(2'h3);
		rd(`FQRB_OFF_STATUS, 32'h2);
		bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		frame(2'h3);
		rd(`FQRB_OFF_STATUS, 32'h0);
		// alter one compared field at a time
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			if (k == 0) da <= {seed[15:0], seed};
			else if (k == 1) sa <= {seed, seed[31:16]};
			else info <= seed;
			frame(2'h3);
			rd(`FQRB_OFF_STATUS, 32'h8);
			bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		end
		bus(1'b1, `FQRB_OFF_CTRL, 32'h1);
		tokp();
		bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		tokp();
		rd(`FQRB_OFF_STATUS, 32'h0);
		frame(2'h0);
		tokp();
		rd(`FQRB_OFF_STATUS, 32'h1);
		pend <= 1'b1;
		cap <= 1'b1;
		@(posedge clk);
		cap <= 1'b0;
		pend <= 1'b0;
		@(negedge clk);
		check({31'h0, gnt}, 32'h1);
		@(posedge clk);
		bus(1'b1, `FQRB_OFF_CTRL, 32'h8);
		bus(1'b1, `FQRB_OFF_CLEAR, 32'h3f);
		bus(1'b1, `FQRB_OFF_NOTIFY, 32'h10);
		slow <= 1'b1;
		seed = lfsr(seed);
		uid <= seed[7:0];
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		rd(`FQRB_OFF_STATUS, 32'h10);
		check(la, 32'h1000);
		check(lw, {24'h0, uid});
		irq_is(1'b1);
		freq <= 1'b1;
		slow <= 1'b0;
		bus(1'b1, `FQRB_OFF_PTR_REQ, 32'h3);
		freq <= 1'b0;
		rd(`FQRB_OFF_PTR_VAL, 32'h5a5a_000c);
		rd(`FQRB_OFF_STATUS, 32'h30);
		rd(`FQRB_OFF_LIM_VAL, 32'hbeef);
		report_and_stop();
	end
endmodule
